// [shared/wsru_regs.vh]
// Opcodes, control word fields and reset values of the word shift/rotate unit
`ifndef WSRU_REGS_VH
`define WSRU_REGS_VH

// Instruction codes on op
`define WSRU_OP_ARITH_LEFT_SHIFT  4'h0
`define WSRU_OP_ARITH_RIGHT_SHIFT 4'h1
`define WSRU_OP_ROTATE_UP         4'h2
`define WSRU_OP_ROTATE_DOWN       4'h3
`define WSRU_OP_DIGIT_UP_SHIFT    4'h4
`define WSRU_OP_DIGIT_DOWN_SHIFT  4'h5
`define WSRU_OP_ZERO_GAP_SHIFT    4'h6
`define WSRU_OP_CARRY_SET         4'h7
`define WSRU_OP_CARRY_CLEAR       4'h8

// Control word of the zero-gap word shifter
`define WSRU_CTL_DIR_BIT    13
`define WSRU_CTL_ENABLE_BIT 14
`define WSRU_CTL_CLEAR_BIT  15

// Word layout
`define WSRU_MSB        15
`define WSRU_LSB        0
`define WSRU_DIGIT_W    4

// Area code of the data memory area used by indirect operands
`define WSRU_DM_AREA    2'h3

// Reset values
`define WSRU_CARRY_RST  1'b0
`define WSRU_ZERO_RST   1'b0
`define WSRU_NEG_RST    1'b0
`define WSRU_FAULT_RST  1'b0

`endif

// [verilog/wsru_word_ram.v]
// Word memory of the shift unit: one write port, one combinational read port
`timescale 1ns/10ps
module wsru_word_ram #(
  parameter AW = 8,
  parameter DW = 16
) (
  clk,
  we,
  waddr,
  wdata,
  raddr,
  rdata
);
  input  wire          clk;
  input  wire          we;
  input  wire [AW-1:0] waddr;
  input  wire [DW-1:0] wdata;
  input  wire [AW-1:0] raddr;
  output wire [DW-1:0] rdata;

  // Contents are program data, so no reset; loaded by the host port
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule

// [verilog/wsru_core.v]
// Word shift/rotate unit: single-word shifts, digit shifts, zero-gap word shifter
//
// Function
// - False execution condition: no word or flag changes, no operation.
// - Left shift: bits up one, zero into bit 0, old bit 15 to carry.
// - Right shift: bits down one, zero into bit 15, old bit 0 to carry.
// - Rotate up: bits up one, old carry into bit 0, bit 15 to carry.
// - Rotate down: bits down one, old carry into bit 15, bit 0 to carry.
// - Single-word ops set zero flag when the result is all zeros, else clear.
// - Carry is cleared at scan end, except in a cycle where a single-word or carry op writes it.
// - Digit up shift moves range up four bits, zero in, top digit lost.
// - Digit down shift moves range down four bits, zero in, low digit lost.
// - Fault when start and end differ in area or start exceeds end.
// - Fault when an indirect pointer is not BCD or exceeds the data area.
// - A word moves only into an adjacent zero word, one per zero word.
// - Moved word's old location becomes zero, zero swaps with next word.
// - Control bit 13: one shifts toward lower, zero toward higher; 0..12 ignored.
// - Control bit 14 enables shifting; clear suppresses all shifting.
// - Control bit 15 clears every word from start through end.
`timescale 1ns/10ps
`include "wsru_regs.vh"

module wsru_core #(
  parameter AW  = 8,
  parameter ARW = 2
) (
  clk,
  rst,
  exec_stb,
  exec_cond,
  op,
  addr_a,
  addr_b,
  ind_a,
  ind_b,
  ptr_a,
  ptr_b,
  ctrl_word,
  scan_end,
  host_we,
  host_addr,
  host_wdata,
  host_rdata,
  busy,
  done,
  carry_bit,
  zero_result_flag,
  neg_flag,
  fault_flag
);
  input  wire          clk;
  input  wire          rst;
  input  wire          exec_stb;
  input  wire          exec_cond;
  input  wire [3:0]    op;
  input  wire [AW-1:0] addr_a;
  input  wire [AW-1:0] addr_b;
  input  wire          ind_a;
  input  wire          ind_b;
  input  wire [15:0]   ptr_a;
  input  wire [15:0]   ptr_b;
  input  wire [15:0]   ctrl_word;
  input  wire          scan_end;
  input  wire          host_we;
  input  wire [AW-1:0] host_addr;
  input  wire [15:0]   host_wdata;
  output reg  [15:0]   host_rdata;
  output reg           busy;
  output reg           done;
  output reg           carry_bit;
  output reg           zero_result_flag;
  output reg           neg_flag;
  output reg           fault_flag;

  localparam OFFW = AW - ARW;
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_RUN  = 2'h1;
  localparam [1:0] S_WR2  = 2'h2;

  // Nibble-wise BCD check of a pointer word
  function bcd_ok;
    input [15:0] w;
    begin
      bcd_ok = (w[3:0] < 4'ha) && (w[7:4] < 4'ha) && (w[11:8] < 4'ha) && (w[15:12] < 4'ha);
    end
  endfunction

  // Binary value of a BCD pointer word
  function [13:0] bcd_val;
    input [15:0] w;
    reg   [31:0] v;
    begin
      v = w[15:12] * 1000 + w[11:8] * 100 + w[7:4] * 10 + w[3:0];
      bcd_val = v[13:0];
    end
  endfunction

  // Pointer must be BCD and land inside the data memory area
  function ptr_ok;
    input [15:0] w;
    begin
      ptr_ok = bcd_ok(w) && (bcd_val(w) < (14'h1 << OFFW));
    end
  endfunction

  function [AW-1:0] ptr_addr;
    input [15:0] w;
    reg   [13:0] v;
    begin
      v = bcd_val(w);
      ptr_addr = {`WSRU_DM_AREA, v[OFFW-1:0]};
    end
  endfunction

  reg  [1:0]    state_r;
  reg  [3:0]    op_r;
  reg  [AW-1:0] cur_r;
  reg  [AW-1:0] lim_r;
  reg  [AW-1:0] prev_r;
  reg           desc_r;
  reg           hold_r;
  reg  [3:0]    dig_r;
  reg  [2:0]    ctl_r;

  wire [15:0]   mem_rdata;
  reg           mem_we;
  reg  [AW-1:0] mem_waddr;
  reg  [15:0]   mem_wdata;
  wire [AW-1:0] mem_raddr;

  // Operand resolution and fault detection
  wire [AW-1:0] start_a = ind_a ? ptr_addr(ptr_a) : addr_a;
  wire [AW-1:0] end_b   = ind_b ? ptr_addr(ptr_b) : addr_b;
  wire          is_multi = (op == `WSRU_OP_DIGIT_UP_SHIFT) || (op == `WSRU_OP_DIGIT_DOWN_SHIFT) ||
                           (op == `WSRU_OP_ZERO_GAP_SHIFT);
  wire          is_carry = (op == `WSRU_OP_CARRY_SET) || (op == `WSRU_OP_CARRY_CLEAR);
  wire          ptr_bad  = (!is_carry && ind_a && !ptr_ok(ptr_a)) ||
                           (is_multi && ind_b && !ptr_ok(ptr_b));
  wire          range_bad = is_multi && ((start_a[AW-1:OFFW] != end_b[AW-1:OFFW]) ||
                                         (start_a > end_b));
  wire          op_fault = ptr_bad || range_bad;
  // Zero-gap shift toward higher addresses walks the range from the top down
  wire          walk_desc = (op == `WSRU_OP_DIGIT_DOWN_SHIFT) ||
                            ((op == `WSRU_OP_ZERO_GAP_SHIFT) && !ctrl_word[`WSRU_CTL_DIR_BIT]);

  wire          last_word = (cur_r == lim_r);
  wire [AW-1:0] cur_step  = desc_r ? cur_r - {{(AW-1){1'b0}}, 1'b1} : cur_r + {{(AW-1){1'b0}}, 1'b1};

  // Single-word result and carry out
  reg  [15:0]   sw_res;
  reg           sw_cy;
  always @* begin
    sw_res = mem_rdata;
    sw_cy  = carry_bit;
    case (op_r)
      `WSRU_OP_ARITH_LEFT_SHIFT: begin
        sw_res = {mem_rdata[14:0], 1'b0};
        sw_cy  = mem_rdata[`WSRU_MSB];
      end
      `WSRU_OP_ARITH_RIGHT_SHIFT: begin
        sw_res = {1'b0, mem_rdata[15:1]};
        sw_cy  = mem_rdata[`WSRU_LSB];
      end
      `WSRU_OP_ROTATE_UP: begin
        sw_res = {mem_rdata[14:0], carry_bit};
        sw_cy  = mem_rdata[`WSRU_MSB];
      end
      `WSRU_OP_ROTATE_DOWN: begin
        sw_res = {carry_bit, mem_rdata[15:1]};
        sw_cy  = mem_rdata[`WSRU_LSB];
      end
      default: begin
        sw_res = mem_rdata;
        sw_cy  = carry_bit;
      end
    endcase
  end

  wire is_single = (op_r == `WSRU_OP_ARITH_LEFT_SHIFT) || (op_r == `WSRU_OP_ARITH_RIGHT_SHIFT) ||
                   (op_r == `WSRU_OP_ROTATE_UP) || (op_r == `WSRU_OP_ROTATE_DOWN);
  wire swap_now  = (op_r == `WSRU_OP_ZERO_GAP_SHIFT) && ctl_r[1] && hold_r && (mem_rdata != 16'h0000);

  // Memory write port: the host owns it while idle
  always @* begin
    mem_we    = 1'b0;
    mem_waddr = cur_r;
    mem_wdata = 16'h0000;
    case (state_r)
      S_IDLE: begin
        mem_we    = host_we;
        mem_waddr = host_addr;
        mem_wdata = host_wdata;
      end
      S_RUN: begin
        if (is_single) begin
          mem_we    = 1'b1;
          mem_wdata = sw_res;
        end else if (op_r == `WSRU_OP_DIGIT_UP_SHIFT) begin
          mem_we    = 1'b1;
          mem_wdata = {mem_rdata[11:0], dig_r};
        end else if (op_r == `WSRU_OP_DIGIT_DOWN_SHIFT) begin
          mem_we    = 1'b1;
          mem_wdata = {dig_r, mem_rdata[15:4]};
        end else if (ctl_r[2] && (op_r == `WSRU_OP_ZERO_GAP_SHIFT)) begin
          mem_we    = 1'b1;
          mem_wdata = 16'h0000;
        end else if (swap_now) begin
          mem_we    = 1'b1;
          mem_waddr = prev_r;
          mem_wdata = mem_rdata;
        end
      end
      S_WR2: begin
        mem_we    = 1'b1;
        mem_wdata = 16'h0000;
      end
      default: begin
        mem_we = 1'b0;
      end
    endcase
  end

  assign mem_raddr = (state_r == S_IDLE) ? host_addr : cur_r;

  wsru_word_ram #(
    .AW (AW),
    .DW (16)
  ) u_ram (
    .clk   (clk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r          <= S_IDLE;
      op_r             <= 4'h0;
      cur_r            <= {AW{1'b0}};
      lim_r            <= {AW{1'b0}};
      prev_r           <= {AW{1'b0}};
      desc_r           <= 1'b0;
      hold_r           <= 1'b0;
      dig_r            <= 4'h0;
      ctl_r            <= 3'h0;
      host_rdata       <= 16'h0000;
      busy             <= 1'b0;
      done             <= 1'b0;
      carry_bit        <= `WSRU_CARRY_RST;
      zero_result_flag <= `WSRU_ZERO_RST;
      neg_flag         <= `WSRU_NEG_RST;
      fault_flag       <= `WSRU_FAULT_RST;
    end else begin
      done <= 1'b0;
      if (scan_end) begin
        carry_bit <= 1'b0;
      end
      case (state_r)
        S_IDLE: begin
          host_rdata <= mem_rdata;
          if (exec_stb) begin
            if (!exec_cond) begin
              done <= 1'b1;
            end else if (op_fault) begin
              fault_flag <= 1'b1;
              done       <= 1'b1;
            end else if (is_carry) begin
              fault_flag <= 1'b0;
              carry_bit  <= (op == `WSRU_OP_CARRY_SET);
              done       <= 1'b1;
            end else begin
              fault_flag <= 1'b0;
              op_r       <= op;
              desc_r     <= walk_desc;
              cur_r      <= walk_desc ? end_b : start_a;
              lim_r      <= !is_multi ? start_a : (walk_desc ? start_a : end_b);
              hold_r     <= 1'b0;
              dig_r      <= 4'h0;
              // Bits 0..12 are dropped here on purpose
              ctl_r      <= ctrl_word[15:13];
              busy       <= 1'b1;
              state_r    <= S_RUN;
            end
          end
        end
        S_RUN: begin
          if (is_single) begin
            carry_bit        <= sw_cy;
            zero_result_flag <= (sw_res == 16'h0000);
            neg_flag         <= sw_res[`WSRU_MSB];
          end
          if (op_r == `WSRU_OP_DIGIT_UP_SHIFT) begin
            dig_r <= mem_rdata[15:12];
          end else begin
            dig_r <= mem_rdata[3:0];
          end
          if (swap_now && !ctl_r[2]) begin
            hold_r  <= 1'b0;
            state_r <= S_WR2;
          end else begin
            if (!ctl_r[2] && ctl_r[1]) begin
              // A zero word stays a gap that the next word may fill
              hold_r <= (mem_rdata == 16'h0000);
              prev_r <= cur_r;
            end
            if (is_single || last_word) begin
              busy    <= 1'b0;
              done    <= 1'b1;
              state_r <= S_IDLE;
            end else begin
              cur_r <= cur_step;
            end
          end
        end
        S_WR2: begin
          if (last_word) begin
            busy    <= 1'b0;
            done    <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            state_r <= S_RUN;
            cur_r   <= cur_step;
          end
        end
        default: begin
          busy    <= 1'b0;
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// [bench/wsru_core_asserts.sv]
// Port checker of the word shift/rotate unit
`timescale 1ns/10ps
module wsru_core_asserts #(
  parameter AW  = 8,
  parameter ARW = 2
) (
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          exec_stb,
  input wire logic          exec_cond,
  input wire logic [3:0]    op,
  input wire logic [AW-1:0] addr_a,
  input wire logic [AW-1:0] addr_b,
  input wire logic          ind_a,
  input wire logic          ind_b,
  input wire logic [15:0]   ptr_a,
  input wire logic          scan_end,
  input wire logic          busy,
  input wire logic          done,
  input wire logic          carry_bit,
  input wire logic          neg_flag,
  input wire logic          fault_flag
);
  wire logic tk = exec_stb && !busy;
  wire logic go = tk && exec_cond;
  reg  [4:0] op_r;
  always @(posedge clk or posedge rst) begin
    if (rst)
      op_r <= 5'h0;
    else if (tk)
      op_r <= {exec_cond, op};
  end
  a_skip_done: assert property (@(posedge clk) disable iff (rst)
    tk && !exec_cond |=> done && !busy) else $error("skipped op timing");
  a_skip_flags: assert property (@(posedge clk) disable iff (rst)
    tk && !exec_cond |=> $stable(carry_bit) && $stable(neg_flag) && $stable(fault_flag)) else $error("flags moved");
  a_single_time: assert property (@(posedge clk) disable iff (rst)
    go && op < 4'h4 && !ind_a |=> busy ##1 (done && !busy)) else $error("single op timing");
  a_right_neg: assert property (@(posedge clk) disable iff (rst)
    done && op_r == 5'h11 && !fault_flag |-> !neg_flag) else $error("right shift negative");
  a_scan_clear: assert property (@(posedge clk) disable iff (rst)
    scan_end && !busy && !exec_stb |=> !carry_bit) else $error("carry kept at scan end");
  a_range_fault: assert property (@(posedge clk) disable iff (rst)
    go && op > 4'h3 && op < 4'h7 && !ind_a && !ind_b
    && (addr_a > addr_b || addr_a[AW-1 -: ARW] != addr_b[AW-1 -: ARW]) |=> done && fault_flag)
    else $error("range fault missed");
  a_ptr_fault: assert property (@(posedge clk) disable iff (rst)
    go && op < 4'h7 && ind_a && ptr_a[3:0] > 4'h9 |=> done && fault_flag) else $error("pointer fault missed");
  a_fault_clear: assert property (@(posedge clk) disable iff (rst)
    go && op == 4'h8 |=> done && !fault_flag && !carry_bit) else $error("fault not cleared");
  a_busy_bound: assert property (@(posedge clk) disable iff (rst)
    $rose(busy) |-> ##[1:400] done) else $error("operation hangs");
endmodule

bind wsru_core wsru_core_asserts #(.AW(AW), .ARW(ARW)) wsru_core_asserts_inst (
  .clk(clk), .rst(rst), .exec_stb(exec_stb), .exec_cond(exec_cond), .op(op), .addr_a(addr_a),
  .addr_b(addr_b), .ind_a(ind_a), .ind_b(ind_b), .ptr_a(ptr_a), .scan_end(scan_end), .busy(busy),
  .done(done), .carry_bit(carry_bit), .neg_flag(neg_flag), .fault_flag(fault_flag));

// [bench/wsru_seq_model.sv]
// Instruction sequencer model: issues instructions and scan-end pulses
`timescale 1ns/10ps
module wsru_seq_model (
  input  wire logic  clk,
  input  wire logic  done,
  output logic       exec_stb,
  output logic       exec_cond,
  output logic [3:0] op,
  output logic [7:0] addr_a,
  output logic [7:0] addr_b,
  output logic       ind_a,
  output logic       ind_b,
  output logic [15:0] ptr_a,
  output logic [15:0] ptr_b,
  output logic [15:0] ctrl_word,
  output logic       scan_end,
  output logic       run_hung
);
  initial begin
    {exec_stb, exec_cond, op, addr_a, addr_b, ind_a, ind_b} = '0;
    {ptr_a, ptr_b, ctrl_word, scan_end, run_hung} = '0;
  end
  task run(input logic c, input logic [3:0] o, input logic [7:0] a, input logic [7:0] b,
           input logic ia, input logic [15:0] pa, input logic [15:0] cw);
    int n;
    n = 0;
    @(posedge clk);
    exec_stb <= 1'b1;
    exec_cond <= c;
    op <= o;
    addr_a <= a;
    addr_b <= b;
    ind_a <= ia;
    ptr_a <= pa;
    ptr_b <= pa;
    // One pointer serves both ends, so an indirect range is one word
    ind_b <= ia;
    ctrl_word <= cw;
    @(posedge clk);
    exec_stb <= 1'b0;
    // Released operands change so a late sample shows
    op <= ~o;
    addr_a <= ~a;
    #1;
    while (!done && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (!done) run_hung <= 1'b1;
  endtask
  task scan;
    @(posedge clk);
    scan_end <= 1'b1;
    @(posedge clk);
    scan_end <= 1'b0;
  endtask
endmodule

// [bench/wsru_core_tb_top.sv]
// Testbench of the word shift/rotate unit
`timescale 1ns/10ps
module wsru_core_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        host_we = 1'b0;
  logic [7:0]  host_addr = 8'h0;
  logic [15:0] host_wdata = 16'h0;
  wire  [15:0] host_rdata, ptr_a, ptr_b, ctrl_word;
  wire  [7:0]  addr_a, addr_b;
  wire  [3:0]  op;
  wire         exec_stb, exec_cond, ind_a, ind_b, scan_end, busy, done, run_hung;
  wire         carry_bit, zero_result_flag, neg_flag, fault_flag;
  int          num_errors = 0;
  int          n_compared = 0;
  logic [15:0] pre [11] = '{16'h1234, 0, 0, 16'h2345, 16'h3456, 0, 16'h4567, 16'h5678, 16'h6789, 0, 16'h789a};
  logic [15:0] post [11] = '{16'h1234, 0, 16'h2345, 0, 16'h3456, 16'h4567, 0, 16'h5678, 16'h6789, 16'h789a, 0};

  always #50 clk = ~clk;

  wsru_core wsru_core_inst (.clk(clk), .rst(rst), .exec_stb(exec_stb), .exec_cond(exec_cond), .op(op),
    .addr_a(addr_a), .addr_b(addr_b), .ind_a(ind_a), .ind_b(ind_b), .ptr_a(ptr_a), .ptr_b(ptr_b),
    .ctrl_word(ctrl_word), .scan_end(scan_end), .host_we(host_we), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .busy(busy), .done(done), .carry_bit(carry_bit),
    .zero_result_flag(zero_result_flag), .neg_flag(neg_flag), .fault_flag(fault_flag));
  wsru_seq_model wsru_seq_model_inst (.clk(clk), .done(done), .exec_stb(exec_stb), .exec_cond(exec_cond),
    .op(op), .addr_a(addr_a), .addr_b(addr_b), .ind_a(ind_a), .ind_b(ind_b), .ptr_a(ptr_a),
    .ptr_b(ptr_b), .ctrl_word(ctrl_word), .scan_end(scan_end), .run_hung(run_hung));

  function automatic logic [16:0] sw(input logic [1:0] o, input logic [15:0] v, input logic c);
    case (o)
      2'h0: return {v, 1'b0};
      2'h1: return {v[0], 1'b0, v[15:1]};
      2'h2: return {v, c};
      default: return {v[0], c, v[15:1]};
    endcase
  endfunction
  task check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    host_we <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clk);
    host_we <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [15:0] x);
    @(posedge clk);
    host_addr <= a;
    repeat (2) @(posedge clk);
    #1;
    check(host_rdata, x);
  endtask
  task t_single;
    logic [15:0] v;
    logic [16:0] e;
    for (int k = 0; k < 8; k++) begin
      v = k[2] ? 16'h0001 : 16'hc003;
      wr(8'h05, v);
      wsru_seq_model_inst.run(1'b1, k[2] ? 4'h7 : 4'h8, 8'h0, 8'h0, 1'b0, 16'h0, 16'h0);
      wsru_seq_model_inst.run(1'b1, {2'b00, k[1:0]}, 8'h05, 8'h0, 1'b0, 16'h0, 16'h0);
      e = sw(k[1:0], v, k[2]);
      rdc(8'h05, e[15:0]);
      check({15'h0, carry_bit}, {15'h0, e[16]});
      check({15'h0, zero_result_flag}, {15'h0, e[15:0] == 16'h0});
      check({15'h0, neg_flag}, {15'h0, e[15]});
    end
    $display("single word ops done");
  endtask
  task t_skip;
    wr(8'h05, 16'h8001);
    wsru_seq_model_inst.run(1'b1, 4'h7, 8'h0, 8'h0, 1'b0, 16'h0, 16'h0);
    wsru_seq_model_inst.run(1'b0, 4'h0, 8'h05, 8'h0, 1'b0, 16'h0, 16'h0);
    rdc(8'h05, 16'h8001);
    check({15'h0, carry_bit}, 16'h1);
    wsru_seq_model_inst.scan();
    #1;
    check({15'h0, carry_bit}, 16'h0);
    $display("skip and scan end done");
  endtask
  task t_digit;
    for (int i = 0; i < 3; i++)
      wr(8'h10 + i[7:0], 16'h1234 + 16'h4444 * i[15:0]);
    wsru_seq_model_inst.run(1'b1, 4'h4, 8'h10, 8'h12, 1'b0, 16'h0, 16'h0);
    rdc(8'h10, 16'h2340);
    rdc(8'h11, 16'h6781);
    rdc(8'h12, 16'habc5);
    for (int i = 0; i < 3; i++)
      wr(8'h10 + i[7:0], 16'h1234 + 16'h4444 * i[15:0]);
    wsru_seq_model_inst.run(1'b1, 4'h5, 8'h10, 8'h12, 1'b0, 16'h0, 16'h0);
    rdc(8'h10, 16'h8123);
    rdc(8'h11, 16'hc567);
    rdc(8'h12, 16'h09ab);
    $display("digit shifts done");
  endtask
  task flt(input logic [3:0] o, input logic [7:0] a, input logic [7:0] b, input logic ia, input logic [15:0] pa);
    wsru_seq_model_inst.run(1'b1, 4'h8, 8'h0, 8'h0, 1'b0, 16'h0, 16'h0);
    check({15'h0, fault_flag}, 16'h0);
    wsru_seq_model_inst.run(1'b1, o, a, b, ia, pa, 16'h0);
    check({15'h0, fault_flag}, 16'h1);
  endtask
  task t_fault;
    flt(4'h4, 8'h12, 8'h10, 1'b0, 16'h0);
    flt(4'h5, 8'h10, 8'h50, 1'b0, 16'h0);
    flt(4'h0, 8'h10, 8'h0, 1'b1, 16'h001a);
    flt(4'h2, 8'h10, 8'h0, 1'b1, 16'h0064);
    wr(8'hcc, 16'h4001);
    wsru_seq_model_inst.run(1'b1, 4'h0, 8'h10, 8'h0, 1'b1, 16'h0012, 16'h0);
    rdc(8'hcc, 16'h8002);
    check({15'h0, fault_flag}, 16'h0);
    // Enable bit left set: a digit shift must ignore it
    wsru_seq_model_inst.run(1'b1, 4'h4, 8'h10, 8'h0, 1'b1, 16'h0012, 16'h4000);
    rdc(8'hcc, 16'h0020);
    rdc(8'h10, 16'h8123);
    rdc(8'h12, 16'h09ab);
    $display("faults done");
  endtask
  task t_zgap;
    for (int i = 0; i < 11; i++)
      wr(8'hc0 + i[7:0], pre[i]);
    // Low control bits set on purpose: they must be ignored
    wsru_seq_model_inst.run(1'b1, 4'h6, 8'hc0, 8'hca, 1'b0, 16'h0, 16'h6123);
    for (int i = 0; i < 11; i++)
      rdc(8'hc0 + i[7:0], post[i]);
    wsru_seq_model_inst.run(1'b1, 4'h6, 8'hc0, 8'hca, 1'b0, 16'h0, 16'h2000);
    for (int i = 0; i < 11; i++)
      rdc(8'hc0 + i[7:0], post[i]);
    wsru_seq_model_inst.run(1'b1, 4'h6, 8'hc0, 8'hc4, 1'b0, 16'h0, 16'h8000);
    for (int i = 0; i < 6; i++)
      rdc(8'hc0 + i[7:0], i < 5 ? 16'h0 : post[5]);
    wr(8'hd0, 16'h1111);
    wr(8'hd1, 16'h0);
    wr(8'hd2, 16'h2222);
    wsru_seq_model_inst.run(1'b1, 4'h6, 8'hd0, 8'hd2, 1'b0, 16'h0, 16'h4000);
    rdc(8'hd0, 16'h0);
    rdc(8'hd1, 16'h1111);
    rdc(8'hd2, 16'h2222);
    $display("zero gap shifter done");
  endtask
  task report_and_stop;
    if (run_hung !== 1'b0)
      num_errors++;
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_single();
    t_skip();
    t_digit();
    t_fault();
    t_zgap();
    report_and_stop();
  end
  // Whole run needs a few hundred cycles; twenty thousand is ample
  initial begin
    #2000000;
    num_errors++;
    report_and_stop();
  end
endmodule
